// file: dv/ocr_pack_model.sv
// Behavioural pack: current comparators and load-sense pin.
// Assumes the block's FET outputs switch the only current path.
module ocr_pack_model (
	// Fault requests from the bench {short, charge, discharge}
	input  wire logic [2:0] evt_in,
	input  wire logic       load_on_in,
	// Block outputs
	input  wire logic       dfet_on_in,
	input  wire logic       cfet_on_in,
	input  wire logic       sink_en_in,
	// Comparator levels
	output logic            doc_cmp_out,
	output logic            coc_cmp_out,
	output logic            scd_cmp_out,
	output logic            load_cmp_out
);
	// ============================================================
	// Current only flows while both FETs conduct, so a trip ends it
	assign doc_cmp_out  = evt_in[0] & dfet_on_in & cfet_on_in;
	assign coc_cmp_out  = evt_in[1] & dfet_on_in & cfet_on_in;
	assign scd_cmp_out  = evt_in[2] & dfet_on_in & cfet_on_in;
	// Without the sink the pin floats up towards pack voltage
	assign load_cmp_out = load_on_in | ~sink_en_in;
endmodule : ocr_pack_model

// file: dv/ocr_top_tb.sv
// Self-checking bench for the overcurrent response block.
// Assumes the strobe register port and the pack model beside it.
module ocr_top_tb
	import ocr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Signals
	logic       sys_clk_in   = 1'b0;
	logic       arst_n_in    = 1'b0;
	logic [7:0] reg_addr_in  = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic       reg_wr_in    = 1'b0;
	logic       reg_rd_in    = 1'b0;
	logic [2:0] evt          = 3'h0;
	logic       load_on      = 1'b0;
	logic [7:0] reg_rdata_out;
	logic       doc_c, coc_c, scd_c, ld_c, dfet, cfet, wake, sink, ind;
	logic [3:0] aosel;
	int         miscompares  = 0;
	int         checks       = 0;
	int         cycles       = 0;
	int         dly [3]      = '{DOC_DLY_CYC, COC_DLY_CYC, SCD_DLY_CYC};
	always #10 sys_clk_in = ~sys_clk_in;
	// ============================================================
	// Design and pack
	ocr_top ocr_top_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.doc_cmp_in(doc_c), .coc_cmp_in(coc_c), .scd_cmp_in(scd_c),
		.load_sense_cmp_in(ld_c), .dfet_on_out(dfet), .cfet_on_out(cfet),
		.thermistor_supply_wake_out(wake), .load_sink_en_out(sink),
		.load_present_indication_out(ind), .analog_out_select_out(aosel));
	ocr_pack_model ocr_pack_model_inst (.evt_in(evt), .load_on_in(load_on),
		.dfet_on_in(dfet), .cfet_on_in(cfet), .sink_en_in(sink),
		.doc_cmp_out(doc_c), .coc_cmp_out(coc_c), .scd_cmp_out(scd_c),
		.load_cmp_out(ld_c));
	// ============================================================
	// Tasks
	task automatic end_of_test();
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : cyc
	// Compares {dfet, cfet, wake}
	task automatic outs(input logic [2:0] e);
		chk({5'h00, dfet, cfet, wake}, {5'h00, e});
	endtask : outs
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_in  = a;
		reg_wdata_in = d;
		reg_wr_in    = 1'b1;
		cyc(1);
		reg_wr_in    = 1'b0;
		// Idle edge so a following strobe never re-rises in the same step
		cyc(1);
	endtask : wr
	// Read data lands at the edge that samples the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr_in = a;
		reg_rd_in   = 1'b1;
		cyc(1);
		reg_rd_in   = 1'b0;
		chk(reg_rdata_out, e);
		cyc(1);
	endtask : rd
	// ============================================================
	// Hang guard: three trips plus the override run need about 12.5k cycles
	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			end_of_test();
		end
	end
	// ============================================================
	// Main sequence
	initial begin
		cyc(10);
		arst_n_in = 1'b1;
		outs(3'b000);
		rd(ADDR_DCFG, DCFG_RST);
		rd(ADDR_CCFG, CCFG_RST);
		rd(8'h02, 8'h00);
		load_on = 1'b1;
		cyc(6);
		chk({7'h00, ind}, 8'h00);
		wr(ADDR_FETCTL, 8'h04);
		cyc(6);
		chk({6'h00, sink, ind}, 8'h03);
		rd(ADDR_STATUS, 8'h08);
		load_on = 1'b0;
		cyc(6);
		chk({7'h00, ind}, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_FETCTL, 8'h03);
			outs(3'b110);
			evt = 3'h1 << i;
			cyc(dly[i] - 1);
			outs(3'b110);
			cyc(11);
			outs(3'b001);
			evt = 3'h0;
			cyc(20);
			outs(3'b001);
			rd(ADDR_STATUS, 8'h01 << i);
			outs(3'b000);
		end
		wr(ADDR_DCFG, 8'h90);
		wr(ADDR_CCFG, 8'h80);
		rd(ADDR_DCFG, 8'h90);
		rd(ADDR_CCFG, 8'h80);
		wr(ADDR_FETCTL, 8'h03);
		rd(ADDR_FETCTL, 8'h03);
		evt = 3'h7;
		cyc(DOC_DLY_CYC + 12);
		outs(3'b111);
		rd(ADDR_STATUS, 8'h07);
		outs(3'b110);
		wr(ADDR_FETCTL, 8'h00);
		evt = 3'h0;
		outs(3'b000);
		wr(ADDR_AOSEL, {4'h0, AOSEL_EXT_TEMP});
		chk({4'h0, aosel}, {4'h0, AOSEL_EXT_TEMP});
		outs(3'b001);
		rd(ADDR_AOSEL, {4'h0, AOSEL_EXT_TEMP});
		wr(ADDR_STATUS, 8'hff);
		rd(ADDR_STATUS, 8'h00);
		outs(3'b001);
		wr(ADDR_AOSEL, 8'h00);
		outs(3'b000);
		end_of_test();
	end
endmodule : ocr_top_tb

// file: inc/ocr_pkg.sv
// Constants for the overcurrent response and load monitor block.
// Assumes a 50 MHz system clock and a simple register strobe port.
package ocr_pkg;

	// ============================================================
	// Clock and qualification delays
	localparam int CLK_PERIOD_NS = 20;
	localparam int DOC_DLY_US    = 80;
	localparam int COC_DLY_US    = 80;
	localparam int SCD_DLY_US    = 2;
	localparam int DOC_DLY_CYC   = (DOC_DLY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int COC_DLY_CYC   = (COC_DLY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCD_DLY_CYC   = (SCD_DLY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 12;

	// ============================================================
	// Register offsets
	localparam logic [7:0] ADDR_STATUS  = 8'h01;
	localparam logic [7:0] ADDR_DCFG    = 8'h05;
	localparam logic [7:0] ADDR_CCFG    = 8'h06;
	localparam logic [7:0] ADDR_FETCTL  = 8'h08;
	localparam logic [7:0] ADDR_AOSEL   = 8'h09;

	// ============================================================
	// Field positions
	localparam int BIT_DOC_FLAG     = 0;
	localparam int BIT_COC_FLAG     = 1;
	localparam int BIT_SCD_FLAG     = 2;
	localparam int BIT_LOAD_PRESENT = 3;
	localparam int BIT_DOC_DIS      = 7;
	localparam int BIT_SCD_DIS      = 4;
	localparam int BIT_COC_DIS      = 7;
	localparam int BIT_DFET         = 0;
	localparam int BIT_CFET         = 1;
	localparam int BIT_LDMON_EN     = 2;

	// ============================================================
	// Reset values and selector codes
	localparam logic [7:0] DCFG_RST       = 8'h00;
	localparam logic [7:0] CCFG_RST       = 8'h00;
	localparam logic [7:0] FETCTL_RST     = 8'h00;
	localparam logic [3:0] AOSEL_RST      = 4'h0;
	localparam logic [3:0] AOSEL_EXT_TEMP = 4'ha;

endpackage : ocr_pkg

// file: verilog/ocr_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to sys_clk_in.
module ocr_sync3
	import ocr_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk_in,
	input  wire logic arst_n_in,
	// Data
	input  wire logic async_in,
	output logic      level_out
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} ocr_sync_s;

	ocr_sync_s st_q;
	ocr_sync_s st_d;

	// ============================================================
	// Next state
	always_comb begin
		st_d    = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// Stage one is never looked at, only the later two
		if (st_q.s2 == st_q.s3) begin
			st_d.lvl = st_q.s3;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level_out = st_q.lvl;

endmodule : ocr_sync3

// file: verilog/ocr_top.sv
// Overcurrent response, fault status and load monitor control.
// Assumes analog comparators on pins and a host register strobe port.
// How it works
// - Discharge overcurrent turns FETs off unless register 5 bit 7 set
// - Short circuit turns FETs off unless register 5 bit 4 set
// - Charge overcurrent turns FETs off unless register 6 bit 7 set
// - Faults are always detected and flagged, whatever the override bits
// - Flags set only after qualification delay, held in status at 01H
// - Wake output high while any fault flag is set
// - Reading status clears fault flags; wake output drops unless external temperature selected
// - Selecting external temperature on analog output raises wake output
// - Automatic response switches off both discharge and charge FETs
// - Device never turns FETs back on; only host writes do
// - Load monitor idle unless enable bit set; bit enables current sink
// - While enabled, sense pin tied to ground through internal resistor
// - Load indication follows comparator: high above reference, low below
// - Wake output stays on while external temperature is selected
module ocr_top
	import ocr_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       arst_n_in,
	// Register port
	input  wire logic [7:0] reg_addr_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic      [7:0] reg_rdata_out,
	// Comparator inputs
	input  wire logic       doc_cmp_in,
	input  wire logic       coc_cmp_in,
	input  wire logic       scd_cmp_in,
	input  wire logic       load_sense_cmp_in,
	// Outputs
	output logic            dfet_on_out,
	output logic            cfet_on_out,
	output logic            thermistor_supply_wake_out,
	output logic            load_sink_en_out,
	output logic            load_present_indication_out,
	output logic      [3:0] analog_out_select_out
);

	typedef struct packed {
		logic [CNT_W-1:0] doc_cnt;
		logic [CNT_W-1:0] coc_cnt;
		logic [CNT_W-1:0] scd_cnt;
		logic             discharge_oc_flag;
		logic             charge_oc_flag;
		logic             short_circuit_flag;
		logic [7:0]       dcfg;
		logic [7:0]       ccfg;
		logic [7:0]       fetctl;
		logic [3:0]       analog_out_select;
		logic [7:0]       rdata;
		logic             wake;
		logic             load_present;
	} ocr_state_s;

	ocr_state_s st_q;
	ocr_state_s st_d;
	logic       doc_s;
	logic       coc_s;
	logic       scd_s;
	logic       load_s;
	logic       doc_hit;
	logic       coc_hit;
	logic       scd_hit;
	logic       auto_off;
	logic       stat_rd;

	// ============================================================
	// Input synchronisers
	ocr_sync3 u_sync_doc (
		.sys_clk_in (sys_clk_in),
		.arst_n_in  (arst_n_in),
		.async_in   (doc_cmp_in),
		.level_out  (doc_s)
	);
	ocr_sync3 u_sync_coc (
		.sys_clk_in (sys_clk_in),
		.arst_n_in  (arst_n_in),
		.async_in   (coc_cmp_in),
		.level_out  (coc_s)
	);
	ocr_sync3 u_sync_scd (
		.sys_clk_in (sys_clk_in),
		.arst_n_in  (arst_n_in),
		.async_in   (scd_cmp_in),
		.level_out  (scd_s)
	);
	ocr_sync3 u_sync_load (
		.sys_clk_in (sys_clk_in),
		.arst_n_in  (arst_n_in),
		.async_in   (load_sense_cmp_in),
		.level_out  (load_s)
	);

	// ============================================================
	// Helpers
	// Saturating qualification counter; a dropout restarts the delay
	function automatic logic [CNT_W-1:0] qual_step(input logic cond,
			input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
		logic [CNT_W-1:0] r;
		r = '0;
		if (cond && cnt != lim) begin
			r = cnt + 1'b1;
		end else if (cond) begin
			r = cnt;
		end
		return r;
	endfunction : qual_step

	function automatic logic qual_hit(input logic cond,
			input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
		return cond && (cnt == lim - 1'b1);
	endfunction : qual_hit

	always_comb begin
		doc_hit  = qual_hit(doc_s, st_q.doc_cnt, CNT_W'(DOC_DLY_CYC));
		coc_hit  = qual_hit(coc_s, st_q.coc_cnt, CNT_W'(COC_DLY_CYC));
		scd_hit  = qual_hit(scd_s, st_q.scd_cnt, CNT_W'(SCD_DLY_CYC));
		auto_off = (doc_hit && !st_q.dcfg[BIT_DOC_DIS])
			|| (scd_hit && !st_q.dcfg[BIT_SCD_DIS])
			|| (coc_hit && !st_q.ccfg[BIT_COC_DIS]);
		stat_rd  = reg_rd_in && (reg_addr_in == ADDR_STATUS);
	end

	// ============================================================
	// Next state
	always_comb begin
		st_d = st_q;
		st_d.doc_cnt = qual_step(doc_s, st_q.doc_cnt, CNT_W'(DOC_DLY_CYC));
		st_d.coc_cnt = qual_step(coc_s, st_q.coc_cnt, CNT_W'(COC_DLY_CYC));
		st_d.scd_cnt = qual_step(scd_s, st_q.scd_cnt, CNT_W'(SCD_DLY_CYC));
		// Register reads return the value before any clear
		if (reg_rd_in) begin
			case (reg_addr_in)
				ADDR_STATUS: st_d.rdata = {4'h0, st_q.load_present, st_q.short_circuit_flag,
					st_q.charge_oc_flag, st_q.discharge_oc_flag};
				ADDR_DCFG:   st_d.rdata = st_q.dcfg;
				ADDR_CCFG:   st_d.rdata = st_q.ccfg;
				ADDR_FETCTL: st_d.rdata = st_q.fetctl;
				ADDR_AOSEL:  st_d.rdata = {4'h0, st_q.analog_out_select};
				default:     st_d.rdata = 8'h00;
			endcase
		end

		if (stat_rd) begin
			st_d.discharge_oc_flag  = 1'b0;
			st_d.charge_oc_flag     = 1'b0;
			st_d.short_circuit_flag = 1'b0;
		end
		// Set after clear so an event in the read cycle is kept
		if (doc_hit) begin
			st_d.discharge_oc_flag = 1'b1;
		end
		if (coc_hit) begin
			st_d.charge_oc_flag = 1'b1;
		end
		if (scd_hit) begin
			st_d.short_circuit_flag = 1'b1;
		end

		if (reg_wr_in) begin
			case (reg_addr_in)
				ADDR_DCFG:   st_d.dcfg = reg_wdata_in;
				ADDR_CCFG:   st_d.ccfg = reg_wdata_in;
				ADDR_FETCTL: st_d.fetctl = reg_wdata_in;
				ADDR_AOSEL:  st_d.analog_out_select = reg_wdata_in[3:0];
				default:     st_d.fetctl = st_d.fetctl;
			endcase
		end
		// Gate with the new enable so the indication never outlives the sink
		st_d.load_present = load_s && st_d.fetctl[BIT_LDMON_EN];
		// Protection beats a host turn-on in the same cycle
		if (auto_off) begin
			st_d.fetctl[BIT_DFET] = 1'b0;
			st_d.fetctl[BIT_CFET] = 1'b0;
		end

		st_d.wake = st_d.discharge_oc_flag || st_d.charge_oc_flag
			|| st_d.short_circuit_flag
			|| (st_d.analog_out_select == AOSEL_EXT_TEMP);
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_q <= '{doc_cnt: '0, coc_cnt: '0, scd_cnt: '0,
				discharge_oc_flag: 1'b0, charge_oc_flag: 1'b0, short_circuit_flag: 1'b0,
				dcfg: DCFG_RST, ccfg: CCFG_RST, fetctl: FETCTL_RST,
				analog_out_select: AOSEL_RST, rdata: 8'h00, wake: 1'b0,
				load_present: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	// ============================================================
	// Outputs
	assign reg_rdata_out               = st_q.rdata;
	assign dfet_on_out                 = st_q.fetctl[BIT_DFET];
	assign cfet_on_out                 = st_q.fetctl[BIT_CFET];
	assign thermistor_supply_wake_out  = st_q.wake;
	assign load_sink_en_out            = st_q.fetctl[BIT_LDMON_EN];
	assign load_present_indication_out = st_q.load_present;
	assign analog_out_select_out       = st_q.analog_out_select;

	// ============================================================
	// Assertions
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!arst_n_in);

	logic any_flag;
	assign any_flag = st_q.discharge_oc_flag || st_q.charge_oc_flag || st_q.short_circuit_flag;

	property p_doc_off;
		doc_hit && !st_q.dcfg[BIT_DOC_DIS] |=> !dfet_on_out && !cfet_on_out;
	endproperty
	a_doc_off: assert property (p_doc_off) else $error("doc did not cut FETs");

	property p_scd_keep;
		scd_hit && st_q.dcfg[BIT_SCD_DIS] && !doc_hit && !coc_hit && !reg_wr_in
			|=> $stable(st_q.fetctl);
	endproperty
	a_scd_keep: assert property (p_scd_keep) else $error("overridden sc moved FETs");

	property p_coc_off;
		coc_hit && !st_q.ccfg[BIT_COC_DIS] |=> !cfet_on_out && !dfet_on_out;
	endproperty
	a_coc_off: assert property (p_coc_off) else $error("coc did not cut FETs");

	property p_flag_set;
		scd_hit |=> st_q.short_circuit_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("sc flag not set");

	property p_qual;
		$rose(st_q.discharge_oc_flag) |-> $past(st_q.doc_cnt) == CNT_W'(DOC_DLY_CYC - 1);
	endproperty
	a_qual: assert property (p_qual) else $error("doc flag set early");

	property p_wake;
		any_flag |-> thermistor_supply_wake_out;
	endproperty
	a_wake: assert property (p_wake) else $error("wake low with flag set");

	property p_rd_clear;
		stat_rd && !doc_hit && !coc_hit && !scd_hit
			&& st_d.analog_out_select != AOSEL_EXT_TEMP |=> !any_flag ##0 !thermistor_supply_wake_out;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("status read did not clear");

	property p_temp_wake;
		analog_out_select_out == AOSEL_EXT_TEMP |-> thermistor_supply_wake_out;
	endproperty
	a_temp_wake: assert property (p_temp_wake) else $error("temp select without wake");

	property p_no_self_on;
		!reg_wr_in |=> !$rose(dfet_on_out) && !$rose(cfet_on_out);
	endproperty
	a_no_self_on: assert property (p_no_self_on) else $error("FET on without host");

	property p_ldmon;
		load_present_indication_out |-> load_sink_en_out;
	endproperty
	a_ldmon: assert property (p_ldmon) else $error("load indication while idle");

	c_doc_trip:  cover property (doc_hit && !st_q.dcfg[BIT_DOC_DIS] && dfet_on_out);
	c_rd_clear:  cover property (stat_rd && any_flag);
	c_temp_scan: cover property ($rose(analog_out_select_out == AOSEL_EXT_TEMP));

endmodule : ocr_top
